// File: core/ccr_config_regs.v
// Power-on configuration and charge current control registers behind the I2C target
`timescale 1ns/1ps
`default_nettype none
`include "ccr_map.vh"
module ccr_config_regs
#(
   parameter [7:0] CHG_CUR_RESET = `CCR_RST_CHG_CUR_A
)
(
   input  wire        clock,
   input  wire        resetn,
   input  wire        sclIn,
   input  wire        sdaIn,
   output reg         sdaOut,
   output reg         sdaOe,
   output reg         watchdogRestart,
   output reg  [1:0]  chargerOperatingSelect,
   output reg         chargeEnable,
   output reg         boostEnable,
   output reg  [11:0] minimumSystemVoltageMv,
   output reg         boostCurrentLimitSel,
   output reg  [10:0] boostCurrentLimitMa,
   output reg  [12:0] fastChargeCurrentMa,
   output reg         reducedCurrentForce,
   output reg  [7:0]  powerOnConfig,
   output reg  [7:0]  chargeCurrentControl
);
   // ----------------------------------------
   // Bus front end
   // ----------------------------------------
   wire       wrStrobe;
   wire [7:0] wrAddr;
   wire [7:0] wrData;
   wire [7:0] rdAddr;
   reg  [7:0] rdData;
   reg        rdAck;
   reg  [7:0] spareQ [0:7];
   wire       sdaOeRaw;

   ccr_i2c_target uTarget
   (
      .clock    (clock),
      .resetn   (resetn),
      .sclIn    (sclIn),
      .sdaIn    (sdaIn),
      .sdaOe    (sdaOeRaw),
      .rdData   (rdData),
      .rdAck    (rdAck),
      .wrStrobe (wrStrobe),
      .wrAddr   (wrAddr),
      .wrData   (wrData),
      .rdAddr   (rdAddr)
   );

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   reg  [7:0] pwrCfgQ;
   reg  [7:0] chgCurQ;
   wire       wrPwr      = wrStrobe && wrAddr == `CCR_OFS_PWR_CFG;
   wire       wrCur      = wrStrobe && wrAddr == `CCR_OFS_CHG_CUR;
   wire       wrSpare    = wrStrobe && wrAddr <= `CCR_OFS_RW_LAST && !wrPwr && !wrCur;
   wire       regResetCmd = wrPwr && wrData[`CCR_BIT_REG_RESET];

   // Other registers in 0..7 are plain storage here so the full map answers
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : gSpare
         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               spareQ[gi] <= 8'h00;
            else if (wrSpare && wrAddr[2:0] == gi)
               spareQ[gi] <= wrData;
         end
      end
   endgenerate

   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         pwrCfgQ <= `CCR_RST_PWR_CFG;
         chgCurQ <= CHG_CUR_RESET;
      end
      else if (regResetCmd)
      begin
         // Reset command wins over the rest of the written byte
         pwrCfgQ <= `CCR_RST_PWR_CFG;
         chgCurQ <= CHG_CUR_RESET;
      end
      else
      begin
         if (wrPwr)
         begin
            // Command bits are never stored, so they read back as zero
            pwrCfgQ <= {2'b00, wrData[5:0]};
         end
         if (wrCur)
            chgCurQ <= wrData;
      end
   end

   always @*
   begin
      rdAck = 1'b1;
      if (rdAddr == `CCR_OFS_PWR_CFG)
         rdData = pwrCfgQ;
      else if (rdAddr == `CCR_OFS_CHG_CUR)
         rdData = chgCurQ;
      else if (rdAddr <= `CCR_OFS_RW_LAST)
         rdData = spareQ[rdAddr[2:0]];
      else
      begin
         rdData = 8'h00;
         rdAck  = 1'b0;
      end
   end

   // ----------------------------------------
   // Decoded controls
   // ----------------------------------------
   wire [5:0]  ichgCode = chgCurQ[`CCR_BIT_FAST_CHARGE_CURRENT_HI:`CCR_BIT_FAST_CHARGE_CURRENT_LO];
   wire [12:0] ichgFull = `CCR_FAST_CHARGE_CURRENT_BASE_MA + {1'b0, ichgCode, 6'h00};
   wire [2:0]  sysCode  = pwrCfgQ[`CCR_BIT_SYSMIN_HI:`CCR_BIT_SYSMIN_LO];
   wire [11:0] sysMv    = `CCR_SYSMIN_BASE_MV + sysCode * `CCR_SYSMIN_STEP_MV;
   // 20% is taken as a fifth; the integer divide truncates below one mA
   wire [12:0] ichgFifth = ichgFull / 13'd5;

   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         sdaOut                 <= 1'b0;
         sdaOe                  <= 1'b0;
         watchdogRestart        <= 1'b0;
         chargerOperatingSelect <= 2'b01;
         // Reset select is 01, so charging reads enabled to match it
         chargeEnable           <= 1'b1;
         boostEnable            <= 1'b0;
         minimumSystemVoltageMv <= 12'h000;
         boostCurrentLimitSel   <= 1'b1;
         boostCurrentLimitMa    <= `CCR_BOOST_HI_MA;
         fastChargeCurrentMa    <= 13'h0000;
         reducedCurrentForce    <= 1'b0;
         powerOnConfig          <= 8'h00;
         chargeCurrentControl   <= 8'h00;
      end
      else
      begin
         sdaOut <= 1'b0;
         sdaOe  <= sdaOeRaw;
         // One-cycle pulse, not held: the watchdog counts restarts outside this block
         watchdogRestart        <= wrPwr && wrData[`CCR_BIT_WD_RESTART] && !regResetCmd;
         chargerOperatingSelect <= pwrCfgQ[`CCR_BIT_OP_HI:`CCR_BIT_OP_LO];
         chargeEnable           <= pwrCfgQ[`CCR_BIT_OP_HI:`CCR_BIT_OP_LO] == 2'b01;
         boostEnable            <= pwrCfgQ[`CCR_BIT_OP_HI];
         minimumSystemVoltageMv <= sysMv;
         boostCurrentLimitSel   <= pwrCfgQ[`CCR_BIT_BOOST_CURRENT_LIMIT_SEL];
         boostCurrentLimitMa    <= pwrCfgQ[`CCR_BIT_BOOST_CURRENT_LIMIT_SEL] ? `CCR_BOOST_HI_MA : `CCR_BOOST_LO_MA;
         reducedCurrentForce    <= chgCurQ[`CCR_BIT_FORCE];
         // Pre-charge halving is applied downstream from reducedCurrentForce
         fastChargeCurrentMa    <= chgCurQ[`CCR_BIT_FORCE] ? ichgFifth : ichgFull;
         powerOnConfig          <= pwrCfgQ;
         chargeCurrentControl   <= chgCurQ;
      end
   end
endmodule // ccr_config_regs
`default_nettype wire

// File: core/ccr_i2c_target.v
// I2C target front end: start/stop detect, address match, byte shifting, SDA drive
`timescale 1ns/1ps
`default_nettype none
`include "ccr_map.vh"
module ccr_i2c_target
(
   input  wire       clock,
   input  wire       resetn,
   input  wire       sclIn,
   input  wire       sdaIn,
   output reg        sdaOe,
   input  wire [7:0] rdData,
   input  wire       rdAck,
   output reg        wrStrobe,
   output reg  [7:0] wrAddr,
   output reg  [7:0] wrData,
   output reg  [7:0] rdAddr
);
   // ----------------------------------------
   // Bus sampling and edges
   // ----------------------------------------
   reg  sclQ;
   reg  sdaQ;
   wire sclRise = sclIn & ~sclQ;
   wire sclFall = ~sclIn & sclQ;
   wire startEv = sclIn & sclQ & sdaQ & ~sdaIn;
   wire stopEv  = sclIn & sclQ & ~sdaQ & sdaIn;

   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_REG  = 3'd2;
   localparam ST_WDAT = 3'd3;
   localparam ST_RDAT = 3'd4;
   localparam ST_ACK  = 3'd5;
   localparam ST_MACK = 3'd6;

   reg [2:0] stateQ;
   reg [2:0] nextQ;
   reg [3:0] bitCntQ;
   reg [7:0] shiftQ;
   reg [7:0] ptrQ;
   reg       readQ;
   reg       ackBitQ;
   // A refused byte must leave SDA released through its ACK slot, or the controller sees a false ACK
   wire      ackNow = (stateQ == ST_ADDR) ? (shiftQ[7:1] == `CCR_I2C_ADDR) :
                      (stateQ == ST_REG)  ? (shiftQ <= `CCR_OFS_RW_LAST) : 1'b1;

   // Receive and transmit happen on SCL edges so data is only changed while SCL is low
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         sclQ     <= 1'b1;
         sdaQ     <= 1'b1;
         stateQ   <= ST_IDLE;
         nextQ    <= ST_IDLE;
         bitCntQ  <= 4'h0;
         shiftQ   <= 8'h00;
         ptrQ     <= 8'h00;
         readQ    <= 1'b0;
         ackBitQ  <= 1'b0;
         sdaOe    <= 1'b0;
         wrStrobe <= 1'b0;
         wrAddr   <= 8'h00;
         wrData   <= 8'h00;
         rdAddr   <= 8'h00;
      end
      else
      begin
         sclQ     <= sclIn;
         sdaQ     <= sdaIn;
         wrStrobe <= 1'b0;
         if (startEv)
         begin
            stateQ  <= ST_ADDR;
            bitCntQ <= 4'h0;
            sdaOe   <= 1'b0;
         end
         else if (stopEv)
         begin
            stateQ <= ST_IDLE;
            sdaOe  <= 1'b0;
         end
         else if (sclRise && (stateQ == ST_ADDR || stateQ == ST_REG || stateQ == ST_WDAT))
         begin
            shiftQ  <= {shiftQ[6:0], sdaIn};
            bitCntQ <= bitCntQ + 4'h1;
         end
         else if (sclRise && stateQ == ST_RDAT)
            bitCntQ <= bitCntQ + 4'h1;
         else if (sclRise && stateQ == ST_MACK)
         begin
            // Controller NACK ends the read burst
            if (sdaIn)
               stateQ <= ST_IDLE;
            else
            begin
               ptrQ   <= ptrQ + 8'h01;
               rdAddr <= ptrQ + 8'h01;
               stateQ <= ST_RDAT;
            end
            bitCntQ <= 4'h0;
         end
         else if (sclFall)
         begin
            case (stateQ)
               ST_ADDR, ST_REG, ST_WDAT:
                  if (bitCntQ == 4'h8)
                  begin
                     bitCntQ <= 4'h0;
                     stateQ  <= ST_ACK;
                     ackBitQ <= ackNow;
                     nextQ   <= stateQ;
                     if (stateQ == ST_ADDR)
                     begin
                        readQ <= shiftQ[0];
                     end
                     else if (stateQ == ST_REG)
                     begin
                        // Undefined register pointer is refused with NACK
                        ptrQ   <= shiftQ;
                        rdAddr <= shiftQ;
                     end
                     else
                     begin
                        wrStrobe <= 1'b1;
                        wrAddr   <= ptrQ;
                        wrData   <= shiftQ;
                        ptrQ     <= ptrQ + 8'h01;
                     end
                     sdaOe <= ackNow;
                  end
               ST_ACK:
               begin
                  if (!ackBitQ)
                  begin
                     sdaOe  <= 1'b0;
                     stateQ <= ST_IDLE;
                  end
                  else if (nextQ == ST_ADDR && readQ)
                  begin
                     stateQ <= ST_RDAT;
                     // Past the last defined register the bus is left released
                     sdaOe  <= rdAck & ~rdData[7];
                  end
                  else
                  begin
                     sdaOe  <= 1'b0;
                     stateQ <= (nextQ == ST_ADDR) ? ST_REG : ST_WDAT;
                  end
               end
               ST_RDAT:
                  if (bitCntQ == 4'h8)
                  begin
                     sdaOe  <= 1'b0;
                     stateQ <= ST_MACK;
                  end
                  else
                     sdaOe <= rdAck & ~rdData[3'd7 - bitCntQ[2:0]];
               ST_MACK:
                  sdaOe <= rdAck & ~rdData[7];
               default:
                  sdaOe <= 1'b0;
            endcase
         end
      end
   end
endmodule // ccr_i2c_target
`default_nettype wire

// File: core/ccr_map.vh
// Register offsets, field positions, reset values and target address of the charger config registers
`ifndef CCR_MAP_VH
`define CCR_MAP_VH
// ----------------------------------------
// Addresses
// ----------------------------------------
`define CCR_I2C_ADDR        7'h6b
`define CCR_OFS_PWR_CFG     8'h01
`define CCR_OFS_CHG_CUR     8'h02
`define CCR_OFS_RW_LAST     8'h07
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCR_RST_PWR_CFG     8'h1b
`define CCR_RST_CHG_CUR_A   8'h60
`define CCR_RST_CHG_CUR_B   8'h20
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCR_BIT_REG_RESET   7
`define CCR_BIT_WD_RESTART  6
`define CCR_BIT_OP_HI       5
`define CCR_BIT_OP_LO       4
`define CCR_BIT_SYSMIN_HI   3
`define CCR_BIT_SYSMIN_LO   1
`define CCR_BIT_BOOST_CURRENT_LIMIT_SEL   0
`define CCR_BIT_FAST_CHARGE_CURRENT_HI     7
`define CCR_BIT_FAST_CHARGE_CURRENT_LO     2
`define CCR_BIT_FORCE       0
// ----------------------------------------
// Scale figures in millivolts and milliamps
// ----------------------------------------
`define CCR_SYSMIN_BASE_MV  12'h0bb8
`define CCR_SYSMIN_STEP_MV  12'h064
`define CCR_FAST_CHARGE_CURRENT_BASE_MA    13'h0200
`define CCR_FAST_CHARGE_CURRENT_STEP_MA    13'h0040
`define CCR_BOOST_LO_MA     11'h1f4
`define CCR_BOOST_HI_MA     11'h514
`endif

// File: testbench/ccr_config_regs_test.sv
// Self-checking bench for the charger config register block
`timescale 1ns/1ps
`default_nettype none
`include "ccr_map.vh"
module ccr_config_regs_test;
   logic        clock, resetn, scl, sdaRel, sdaOut, sdaOe, wdPulse, chgEn, boostEn, limSel, forceOn;
   logic [1:0]  opSel;
   logic [11:0] sysMv;
   logic [10:0] boostMa;
   logic [12:0] ichgMa;
   logic [7:0]  cfg, cur, rdv, c, k;
   logic [2:0]  nk;
   logic [31:0] lfsr = 32'h46f1eae6;
   int          n_errors = 0, tests_run = 0, wdCount = 0, cycles = 0;
   wire         sdaLine = sdaRel & ~sdaOe;
   ccr_config_regs dut (.clock(clock), .resetn(resetn), .sclIn(scl), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .watchdogRestart(wdPulse), .chargerOperatingSelect(opSel),
      .chargeEnable(chgEn), .boostEnable(boostEn), .minimumSystemVoltageMv(sysMv),
      .boostCurrentLimitSel(limSel), .boostCurrentLimitMa(boostMa), .fastChargeCurrentMa(ichgMa),
      .reducedCurrentForce(forceOn), .powerOnConfig(cfg), .chargeCurrentControl(cur));
   ccr_host_model host (.clock(clock), .sclOut(scl), .sdaRel(sdaRel), .sdaLine(sdaLine));
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Whole run is near 18k cycles; the ceiling leaves ample margin
   always @(posedge clock)
   begin
      cycles++;
      if (wdPulse === 1'b1)
         wdCount++;
      if (cycles == 60000)
      begin
         n_errors++;
         final_report;
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] nextRand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [12:0] expMa(input logic [7:0] v);
      logic [12:0] m;
      m = 13'h0200 + 13'h0040 * v[7:2];
      return v[0] ? m / 5 : m;
   endfunction
   task automatic checkOut(input logic [7:0] a, input logic [7:0] b);
      check(cfg, a);
      check(opSel, a[5:4]);
      check(chgEn, a[5:4] == 2'b01);
      check(boostEn, a[5]);
      check(sysMv, 12'hbb8 + 12'h064 * a[3:1]);
      check(boostMa, a[0] ? 11'h514 : 11'h1f4);
      check(limSel, a[0]);
      check(sdaOut, 1'b0);
      check(ichgMa, expMa(b));
      check(forceOn, b[0]);
      check(cur, b);
   endtask
   task automatic rdChk(input logic [7:0] p, input logic [7:0] e);
      host.rd(p, rdv, nk);
      check({nk, rdv}, {3'b000, e});
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      resetn = 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      repeat (3) @(posedge clock);
      checkOut(8'h1b, 8'h60);
      rdChk(8'h01, 8'h1b);
      rdChk(8'h02, 8'h60);
      // Every operating mode first, then random fields; host keeps bit 1 zero
      for (int i = 0; i < 12; i++)
      begin
         lfsr = nextRand(lfsr);
         c = (i < 4) ? {2'b00, i[1:0], lfsr[3:0]} : lfsr[7:0] & 8'h3f;
         k = (i == 4) ? 8'hfd : (i == 5) ? 8'h00 : lfsr[15:8] & 8'hfd;
         host.wr(`CCR_I2C_ADDR, 8'h01, {c, k}, 2, nk);
         check(nk, 3'b000);
         checkOut(c, k);
         rdChk(8'h01, c);
         rdChk(8'h02, k);
      end
      wdCount = 0;
      host.wr(`CCR_I2C_ADDR, 8'h01, {8'h40 | c, 8'h00}, 1, nk);
      host.wr(`CCR_I2C_ADDR, 8'h01, {8'h40 | c, 8'h00}, 1, nk);
      check(wdCount, 2);
      rdChk(8'h01, c);
      host.wr(`CCR_I2C_ADDR, 8'h08, 16'h0000, 1, nk);
      check(nk[1], 1'b1);
      host.wr(7'h6a, 8'h01, 16'h0000, 1, nk);
      check(nk[2], 1'b1);
      rdChk(8'h01, c);
      host.wr(`CCR_I2C_ADDR, 8'h01, 16'h8000, 1, nk);
      check(wdCount, 2);
      checkOut(8'h1b, 8'h60);
      rdChk(8'h01, 8'h1b);
      rdChk(8'h02, 8'h60);
      final_report;
   end
endmodule // ccr_config_regs_test
`default_nettype wire

// File: testbench/ccr_host_model.sv
// Host I2C controller model; SDA is released high through the pull-up
`timescale 1ns/1ps
`default_nettype none
`include "ccr_map.vh"
module ccr_host_model
(
   input  wire logic clock,
   output var logic  sclOut,
   output var logic  sdaRel,
   input  wire logic sdaLine
);
   initial
   begin
      sclOut = 1'b1;
      sdaRel = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Phases kept at two clocks or more so the target never misses an edge
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--)
      begin
         sdaRel <= d[i];
         hold(3);
         sclOut <= 1'b1;
         hold(3);
         q[i] = sdaLine;
         hold(2);
         sclOut <= 1'b0;
         hold(2);
      end
   endtask
   task automatic startCond;
      sdaRel <= 1'b1;
      hold(2);
      sclOut <= 1'b1;
      hold(4);
      sdaRel <= 1'b0;
      hold(4);
      sclOut <= 1'b0;
      hold(2);
   endtask
   task automatic stopCond;
      sdaRel <= 1'b0;
      hold(2);
      sclOut <= 1'b1;
      hold(4);
      sdaRel <= 1'b1;
      hold(4);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                     input int n, output logic [2:0] nk);
      logic [8:0] q;
      startCond;
      xfer({a, 2'b01}, q);
      nk[2] = q[0];
      xfer({p, 1'b1}, q);
      nk[1] = q[0];
      xfer({d[15:8], 1'b1}, q);
      nk[0] = q[0];
      if (n > 1)
         xfer({d[7:0], 1'b1}, q);
      stopCond;
   endtask
   task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic [2:0] nk);
      logic [8:0] q;
      startCond;
      xfer({`CCR_I2C_ADDR, 2'b01}, q);
      nk[2] = q[0];
      xfer({p, 1'b1}, q);
      nk[1] = q[0];
      startCond;
      xfer({`CCR_I2C_ADDR, 2'b11}, q);
      nk[0] = q[0];
      xfer(9'h1ff, q);
      d = q[8:1];
      stopCond;
   endtask
endmodule // ccr_host_model
`default_nettype wire

// File: testbench/ccr_regs_monitor.sv
// Concurrent checks on the charger config register ports
`timescale 1ns/1ps
`default_nettype none
module ccr_regs_monitor
(
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        sclIn,
   input wire logic        sdaOut,
   input wire logic        sdaOe,
   input wire logic        watchdogRestart,
   input wire logic [1:0]  chargerOperatingSelect,
   input wire logic        chargeEnable,
   input wire logic        boostEnable,
   input wire logic [11:0] minimumSystemVoltageMv,
   input wire logic        boostCurrentLimitSel,
   input wire logic [10:0] boostCurrentLimitMa,
   input wire logic [12:0] fastChargeCurrentMa,
   input wire logic        reducedCurrentForce,
   input wire logic [7:0]  powerOnConfig,
   input wire logic [7:0]  chargeCurrentControl
);
   // Decoded figures are registered in the same cycle as the copies; checks wait for two stable cycles
   logic [12:0] baseMa;
   logic [11:0] sysMv;
   assign baseMa = 13'h0200 + {1'b0, chargeCurrentControl[7:2], 6'h00};
   assign sysMv  = 12'hbb8 + 12'h064 * {9'h000, powerOnConfig[3:1]};
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   opsel_decode_a: assert property ($stable(powerOnConfig)[*2] |->
      chargerOperatingSelect == powerOnConfig[5:4]) else $error("Operating select wrong");
   mode_enables_a: assert property (chargeEnable == (chargerOperatingSelect == 2'b01)
      && boostEnable == chargerOperatingSelect[1]) else $error("Mode enables wrong");
   sysmin_value_a: assert property ($stable(powerOnConfig)[*2] |->
      minimumSystemVoltageMv == sysMv) else $error("System voltage wrong");
   boost_limit_a: assert property (boostCurrentLimitMa ==
      (boostCurrentLimitSel ? 11'h514 : 11'h1f4)) else $error("Boost limit wrong");
   fast_charge_current_value_a: assert property ($stable(chargeCurrentControl)[*2] |->
      reducedCurrentForce == chargeCurrentControl[0] && fastChargeCurrentMa ==
      (chargeCurrentControl[0] ? baseMa / 5 : baseMa)) else $error("Charge current wrong");
   cmd_bits_clear_a: assert property (powerOnConfig[7:6] == 2'b00)
      else $error("Command bit stuck");
   wd_pulse_a: assert property (watchdogRestart |=> !watchdogRestart)
      else $error("Restart pulse too long");
   sda_timing_a: assert property ($changed(sdaOe) |-> !$past(sclIn))
      else $error("SDA moved with SCL high");
   sda_low_a: assert property (sdaOut == 1'b0)
      else $error("SDA output not low");
   cover property (watchdogRestart);
   cover property (boostEnable);
   cover property (reducedCurrentForce);
endmodule // ccr_regs_monitor
bind ccr_config_regs ccr_regs_monitor mon (.clock(clock), .resetn(resetn), .sclIn(sclIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .watchdogRestart(watchdogRestart),
   .chargerOperatingSelect(chargerOperatingSelect), .chargeEnable(chargeEnable),
   .boostEnable(boostEnable), .minimumSystemVoltageMv(minimumSystemVoltageMv),
   .boostCurrentLimitSel(boostCurrentLimitSel), .boostCurrentLimitMa(boostCurrentLimitMa),
   .fastChargeCurrentMa(fastChargeCurrentMa), .reducedCurrentForce(reducedCurrentForce),
   .powerOnConfig(powerOnConfig), .chargeCurrentControl(chargeCurrentControl));
`default_nettype wire
